// File: include/acsc_pkg.sv
// shared constants and types for the analog capture serial control block
package acsc_pkg;
    localparam int GAIN_CMD_W = 8;
    localparam int FIELD_W    = 4;
    localparam int SAMPLE_W   = 14;
    localparam int MAG_W      = 7;

    // readout frame positions, counted in falling serial clock edges
    localparam logic [5:0] FRM_A_FIRST = 6'h02;
    localparam logic [5:0] FRM_A_LAST  = 6'h0F;
    localparam logic [5:0] FRM_B_FIRST = 6'h12;
    localparam logic [5:0] FRM_B_LAST  = 6'h1F;
    localparam logic [5:0] FRM_END     = 6'h22;
    localparam logic [5:0] FRM_START   = 6'h00;

    // gain field codes
    localparam logic [3:0] GC_OFF  = 4'h0;
    localparam logic [3:0] GC_X1   = 4'h1;
    localparam logic [3:0] GC_X2   = 4'h2;
    localparam logic [3:0] GC_X5   = 4'h3;
    localparam logic [3:0] GC_X10  = 4'h4;
    localparam logic [3:0] GC_X20  = 4'h5;
    localparam logic [3:0] GC_X50  = 4'h6;
    localparam logic [3:0] GC_X100 = 4'h7;

    // inverting gain magnitudes
    localparam logic [6:0] MAG_0   = 7'h00;
    localparam logic [6:0] MAG_1   = 7'h01;
    localparam logic [6:0] MAG_2   = 7'h02;
    localparam logic [6:0] MAG_5   = 7'h05;
    localparam logic [6:0] MAG_10  = 7'h0A;
    localparam logic [6:0] MAG_20  = 7'h14;
    localparam logic [6:0] MAG_50  = 7'h32;
    localparam logic [6:0] MAG_100 = 7'h64;

    localparam logic [3:0] AMP_CNT_RST = 4'h0;
    localparam logic [3:0] AMP_CNT_MAX = 4'h8;
    localparam logic [2:0] SYNC_IDLE_HI = 3'h7;
    localparam logic [2:0] SYNC_IDLE_LO = 3'h0;

    // channel b field leads, so it sits in the upper nibble
    typedef struct packed {
        logic [3:0] b;
        logic [3:0] a;
    } acsc_gain_t;

    typedef struct packed {
        logic signed [13:0] a;
        logic signed [13:0] b;
    } acsc_pair_t;

    localparam acsc_gain_t GAIN_RST = 8'h00;
    localparam acsc_pair_t PAIR_RST = 28'h0000000;
endpackage

// File: rtl/acsc_capture.sv
// amplifier gain slave and dual converter readout slave on the shared serial bus
// How it works
// - 8-bit gain command, MSB first, channel b first
// - codes 3..7 give gains -5 to -100
// - gain select is active-low slave select
// - mosi sampled on rising serial clock
// - echo shifts on falling serial clock
// - new gain applied when select rises
// - echo returns previously loaded gain
// - convert rise samples both channels together
// - results read after next convert, one-sample latency
// - readout delivers two samples on miso
// - samples are 14-bit two's complement
// - miso released two cycles around samples
module acsc_capture
    import acsc_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                srst_i,
    input  wire logic                ce_i,
    input  wire logic                spi_sck_i,
    input  wire logic                spi_mosi_i,
    input  wire logic                gain_chip_select_n_i,
    input  wire logic                gain_stage_shutdown_i,
    input  wire logic                convert_strobe_i,
    input  wire logic [SAMPLE_W-1:0] analog_in_a_i,
    input  wire logic [SAMPLE_W-1:0] analog_in_b_i,
    output logic                     gain_echo_out_o,
    output logic                     spi_miso_o,
    output logic                     spi_miso_oe_o,
    output acsc_gain_t               gain_code_o,
    output logic [MAG_W-1:0]         gain_mag_a_o,
    output logic [MAG_W-1:0]         gain_mag_b_o
);
    // ---------------- core domain ----------------
    logic [2:0]         cs_sync;
    logic [2:0]         conv_sync;
    logic [2:0]         shdn_sync;
    logic               cs_lvl;
    logic               conv_lvl;
    logic               link_rst;
    acsc_pair_t         held;
    acsc_pair_t         result;
    logic [2:0]         next_cs_sync;
    logic [2:0]         next_conv_sync;
    logic [2:0]         next_shdn_sync;
    logic               next_cs_lvl;
    logic               next_conv_lvl;
    acsc_gain_t         next_gain;
    logic [MAG_W-1:0]   next_mag_a;
    logic [MAG_W-1:0]   next_mag_b;
    acsc_pair_t         next_held;
    acsc_pair_t         next_result;
    logic               cs_rise;
    logic               conv_rise;
    logic               shdn_on;
    // ---------------- link domain ----------------
    acsc_gain_t         amp_shift;
    logic [3:0]         amp_cnt;
    logic [5:0]         frm_cnt;
    acsc_gain_t         next_amp_shift;
    logic [3:0]         next_amp_cnt;
    logic               next_echo;
    logic [5:0]         next_frm_cnt;
    logic               next_miso;
    logic               next_miso_oe;
    logic               amp_clr;
    logic               frm_clr;

    // gain code to inverting gain magnitude; unused codes give no gain
    function automatic logic [MAG_W-1:0] gain_mag(input logic [FIELD_W-1:0] code);
        logic [MAG_W-1:0] m;
        m = MAG_0;
        unique case (code)
            GC_X1:   m = MAG_1;
            GC_X2:   m = MAG_2;
            GC_X5:   m = MAG_5;
            GC_X10:  m = MAG_10;
            GC_X20:  m = MAG_20;
            GC_X50:  m = MAG_50;
            GC_X100: m = MAG_100;
            default: m = MAG_0;
        endcase
        return m;
    endfunction

    // pin synchronisers: an edge counts once stages two and three agree
    always_comb begin
        next_cs_sync   = {cs_sync[1:0], gain_chip_select_n_i};
        next_conv_sync = {conv_sync[1:0], convert_strobe_i};
        next_shdn_sync = {shdn_sync[1:0], gain_stage_shutdown_i};
        next_cs_lvl    = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_lvl;
        next_conv_lvl  = (conv_sync[1] == conv_sync[2]) ? conv_sync[2] : conv_lvl;
        cs_rise        = (cs_sync[1] == cs_sync[2]) && cs_sync[2] && !cs_lvl;
        conv_rise      = (conv_sync[1] == conv_sync[2]) && conv_sync[2] && !conv_lvl;
        shdn_on        = shdn_sync[1] && shdn_sync[2];
    end

    // gain takes the shifted command only at deselect; link is idle then
    always_comb begin
        next_gain = gain_code_o;
        if (shdn_on) begin
            next_gain = GAIN_RST;
        end else if (cs_rise) begin
            next_gain = amp_shift;
        end
        next_mag_a = gain_mag(next_gain.a);
        next_mag_b = gain_mag(next_gain.b);
    end

    // both channels caught in one cycle, shown one conversion later
    always_comb begin
        next_held   = held;
        next_result = result;
        if (conv_rise) begin
            next_held   = {analog_in_a_i, analog_in_b_i};
            next_result = held;
        end
    end

    // core registers, frozen while the clock enable is low; link_rst follows srst_i regardless
    always_ff @(posedge ref_clk_i) begin
        link_rst <= srst_i;
        if (srst_i) begin
            cs_sync      <= SYNC_IDLE_HI;
            conv_sync    <= SYNC_IDLE_LO;
            shdn_sync    <= SYNC_IDLE_LO;
            cs_lvl       <= 1'b1;
            conv_lvl     <= 1'b0;
            gain_code_o  <= GAIN_RST;
            gain_mag_a_o <= MAG_0;
            gain_mag_b_o <= MAG_0;
            held         <= PAIR_RST;
            result       <= PAIR_RST;
        end else if (ce_i) begin
            cs_sync      <= next_cs_sync;
            conv_sync    <= next_conv_sync;
            shdn_sync    <= next_shdn_sync;
            cs_lvl       <= next_cs_lvl;
            conv_lvl     <= next_conv_lvl;
            gain_code_o  <= next_gain;
            gain_mag_a_o <= next_mag_a;
            gain_mag_b_o <= next_mag_b;
            held         <= next_held;
            result       <= next_result;
        end
    end

    // link clears: deselect or convert; core reset also forces idle
    assign amp_clr = gain_chip_select_n_i | link_rst;
    assign frm_clr = convert_strobe_i | link_rst;

    // command shift on rising clock while selected
    always_comb begin
        next_amp_shift = amp_shift;
        next_amp_cnt   = amp_cnt;
        if (!gain_chip_select_n_i) begin
            next_amp_shift = {amp_shift[GAIN_CMD_W-2:0], spi_mosi_i};
            if (amp_cnt != AMP_CNT_MAX) begin
                next_amp_cnt = amp_cnt + 4'h1;
            end
        end
    end

    // shift data keeps no reset so a deselect cannot corrupt it
    always_ff @(posedge spi_sck_i) begin
        amp_shift <= next_amp_shift;
    end

    always_ff @(posedge spi_sck_i or posedge amp_clr) begin
        if (amp_clr) begin
            amp_cnt <= AMP_CNT_RST;
        end else begin
            amp_cnt <= next_amp_cnt;
        end
    end

    // echo the applied gain, quasi-static while selected, msb first
    always_comb begin
        next_echo = 1'b0;
        if (amp_cnt != AMP_CNT_RST) begin
            next_echo = gain_code_o[3'(AMP_CNT_MAX - amp_cnt)];
        end
    end

    always_ff @(negedge spi_sck_i or posedge amp_clr) begin
        if (amp_clr) begin
            gain_echo_out_o <= 1'b0;
        end else begin
            gain_echo_out_o <= next_echo;
        end
    end

    // readout frame; result words stand still long before clocks start
    always_comb begin
        next_frm_cnt = frm_cnt;
        if (frm_cnt != FRM_END) begin
            next_frm_cnt = frm_cnt + 6'h01;
        end
        next_miso    = 1'b0;
        next_miso_oe = 1'b0;
        if (next_frm_cnt >= FRM_A_FIRST && next_frm_cnt <= FRM_A_LAST) begin
            next_miso_oe = 1'b1;
            next_miso    = result.a[4'(FRM_A_LAST - next_frm_cnt)];
        end else if (next_frm_cnt >= FRM_B_FIRST && next_frm_cnt <= FRM_B_LAST) begin
            next_miso_oe = 1'b1;
            next_miso    = result.b[4'(FRM_B_LAST - next_frm_cnt)];
        end
    end

    // reset parks the frame at its end so stray clocks stay quiet; convert restarts it
    always_ff @(negedge spi_sck_i or posedge link_rst or posedge convert_strobe_i) begin
        if (link_rst) begin
            frm_cnt       <= FRM_END;
            spi_miso_o    <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else if (convert_strobe_i) begin
            frm_cnt       <= FRM_START;
            spi_miso_o    <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else begin
            frm_cnt       <= next_frm_cnt;
            spi_miso_o    <= next_miso;
            spi_miso_oe_o <= next_miso_oe;
        end
    end

    // ---------------- checks ----------------
    logic conv_seen;
    // marks that a real convert has happened since the last reset
    always_ff @(posedge convert_strobe_i or posedge link_rst) begin
        if (link_rst) begin
            conv_seen <= 1'b0;
        end else begin
            conv_seen <= 1'b1;
        end
    end

    property p_idle_quiet;
        @(negedge spi_sck_i) disable iff (frm_clr)
        frm_cnt == FRM_END |-> !spi_miso_oe_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("miso driven while idle");

    property p_apply_gain;
        @(posedge ref_clk_i) disable iff (srst_i)
        cs_rise && ce_i && !shdn_on |=> gain_code_o == $past(amp_shift);
    endproperty
    a_apply_gain: assert property (p_apply_gain) else $error("gain not applied");

    property p_gain_hold;
        @(posedge ref_clk_i) disable iff (srst_i)
        !cs_rise && !shdn_on |=> $stable(gain_code_o);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain moved");

    property p_mag_map;
        @(posedge ref_clk_i) disable iff (srst_i)
        (gain_code_o.a == GC_X10 |-> gain_mag_a_o == MAG_10) and
        (gain_code_o.b == GC_X100 |-> gain_mag_b_o == MAG_100);
    endproperty
    a_mag_map: assert property (p_mag_map) else $error("bad gain decode");

    property p_mag_low;
        @(posedge ref_clk_i) disable iff (srst_i)
        gain_code_o.a == GC_X2 |-> gain_mag_a_o == MAG_2;
    endproperty
    a_mag_low: assert property (p_mag_low) else $error("bad low gain");

    property p_simul;
        @(posedge ref_clk_i) disable iff (srst_i)
        conv_rise && ce_i |=> held.a == $past(analog_in_a_i) && held.b == $past(analog_in_b_i);
    endproperty
    a_simul: assert property (p_simul) else $error("channels not paired");

    property p_latency;
        @(posedge ref_clk_i) disable iff (srst_i)
        conv_rise && ce_i |=> result == $past(held);
    endproperty
    a_latency: assert property (p_latency) else $error("latency wrong");

    property p_frame_window;
        @(negedge spi_sck_i) disable iff (frm_clr)
        spi_miso_oe_o |-> (frm_cnt inside {[FRM_A_FIRST:FRM_A_LAST], [FRM_B_FIRST:FRM_B_LAST]});
    endproperty
    a_frame_window: assert property (p_frame_window) else $error("miso outside window");

    property p_release;
        @(negedge spi_sck_i) disable iff (frm_clr)
        conv_seen && frm_cnt == FRM_B_LAST |=> !spi_miso_oe_o [*2];
    endproperty
    a_release: assert property (p_release) else $error("miso not released");

    c_gain_load: cover property (@(posedge ref_clk_i) cs_rise && !shdn_on);
    c_convert:   cover property (@(posedge ref_clk_i) conv_rise);
    c_frame_end: cover property (@(negedge spi_sck_i) frm_cnt == FRM_END && conv_seen);
    c_shutdown:  cover property (@(posedge ref_clk_i) shdn_on && cs_rise);
    c_echo_one:  cover property (@(negedge spi_sck_i) !gain_chip_select_n_i && gain_echo_out_o);
endmodule

// File: tb/acsc_capture_bench.sv
// self-checking bench for the capture serial control block
module acsc_capture_bench;
    import acsc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic            ref_clk_i, srst_i, shdn;
    logic [13:0]     ain_a, ain_b;
    logic            sck, mosi, sel_n, conv, echo, miso, miso_oe;
    acsc_gain_t      gcode;
    logic [6:0]      mag_a, mag_b;
    int              err_count = 0;
    int              num_checks = 0;
    logic [3:0]      codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                                    4'h5, 4'h6, 4'h7, 4'h8, 4'hF};

    // clock enable tied high: freezing is not exercised
    acsc_capture dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .spi_sck_i(sck), .spi_mosi_i(mosi), .gain_chip_select_n_i(sel_n),
        .gain_stage_shutdown_i(shdn), .convert_strobe_i(conv),
        .analog_in_a_i(ain_a), .analog_in_b_i(ain_b), .gain_echo_out_o(echo),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .gain_code_o(gcode),
        .gain_mag_a_o(mag_a), .gain_mag_b_o(mag_b));
    acsc_master_model mm (.sck_o(sck), .mosi_o(mosi), .sel_n_o(sel_n),
        .conv_o(conv), .echo_i(echo), .miso_i(miso), .miso_oe_i(miso_oe));

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string nm, input logic [33:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask

    task automatic core_wait(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    function automatic logic [6:0] exp_mag(input logic [3:0] c);
        case (c)
            4'h1: return 7'h01;
            4'h2: return 7'h02;
            4'h3: return 7'h05;
            4'h4: return 7'h0A;
            4'h5: return 7'h14;
            4'h6: return 7'h32;
            4'h7: return 7'h64;
            default: return 7'h00;
        endcase
    endfunction

    task automatic test_reset();
        chk("gain", gcode, 8'h00);
        chk("mag", {mag_a, mag_b}, 14'h0000);
        chk("oe", miso_oe, 1'b0);
        chk("miso_idle", miso, 1'b0);
        chk("echo_idle", echo, 1'b0);
        $display("test reset done");
    endtask

    // codes 0 to 8 and F on both fields; echo shows the prior setting
    task automatic test_gain();
        logic [7:0] cmd, e, prev;
        prev = 8'h00;
        for (int k = 0; k < 10; k++) begin
            cmd = {codes[9-k], codes[k]};
            mm.load_gain(cmd, e);
            chk("echo", e, prev);
            chk("early", gcode, prev);
            core_wait(8);
            chk("gain", gcode, cmd);
            chk("mag_a", mag_a, exp_mag(codes[k]));
            chk("mag_b", mag_b, exp_mag(codes[9-k]));
            prev = cmd;
        end
        $display("test gain done");
    endtask

    task automatic test_shutdown();
        logic [7:0] e;
        shdn = 1'b1;
        core_wait(6);
        chk("shdn", gcode, 8'h00);
        mm.load_gain(8'h77, e);
        core_wait(8);
        chk("shdn_load", gcode, 8'h00);
        shdn = 1'b0;
        mm.load_gain(8'h34, e);
        core_wait(8);
        chk("resume", gcode, 8'h34);
        $display("test shutdown done");
    endtask

    // frame layout and data for one readout
    task automatic frame(input logic [13:0] a, b, input logic chk_data);
        logic [33:0] oe, bits, eo, eb;
        eo = '0;
        eb = '0;
        mm.read_frame(oe, bits);
        for (int n = 2; n <= 15; n++) begin
            eo[n-1] = 1'b1;
            eb[n-1] = a[15-n];
            eo[n+15] = 1'b1;
            eb[n+15] = b[15-n];
        end
        chk("frame_oe", oe, eo);
        if (chk_data)
            chk("frame_bits", bits & eo, eb);
    endtask

    // results of one convert appear only after the next
    task automatic test_readout();
        @(posedge ref_clk_i) #1 {ain_a, ain_b} = {14'h1FFF, 14'h2000};
        frame(14'h0000, 14'h0000, 1'b0);
        @(posedge ref_clk_i) #1 {ain_a, ain_b} = {14'h0155, 14'h3AAA};
        frame(14'h1FFF, 14'h2000, 1'b1);
        frame(14'h0155, 14'h3AAA, 1'b1);
        $display("test readout done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard
    initial begin
        #2ms;
        $display("Error timeout");
        err_count++;
        wrap_up();
    end

    initial begin
        srst_i = 1'b1;
        shdn = 1'b0;
        ain_a = 14'h0000;
        ain_b = 14'h0000;
        repeat (8) @(posedge ref_clk_i);
        #1 srst_i = 1'b0;
        core_wait(2);
        test_reset();
        test_gain();
        test_shutdown();
        test_readout();
        wrap_up();
    end
endmodule

// File: tb/acsc_master_model.sv
// serial bus master model: gain loads and converter readouts
module acsc_master_model (
    output logic      sck_o,
    output logic      mosi_o,
    output logic      sel_n_o,
    output logic      conv_o,
    input  wire logic echo_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // clock stands low between frames, selects idle disabled
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        sel_n_o = 1'b1;
        conv_o = 1'b0;
    end

    // one clock cycle, rise then fall
    task automatic pulse(input int half);
        #(half) sck_o = 1'b1;
        #(half) sck_o = 1'b0;
    endtask

    // slow clock for the gain stage; echo read after each fall
    task automatic load_gain(input logic [7:0] cmd, output logic [7:0] echo);
        sel_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #3 mosi_o = cmd[i];
            pulse(50);
            #1 echo[i] = echo_i;
        end
        #3 sel_n_o = 1'b1;
        mosi_o = ~mosi_o; // released line must not look held
    endtask

    // convert held 5 core cycles, then a full 34 cycle frame
    task automatic read_frame(output logic [33:0] oe, output logic [33:0] bits);
        conv_o = 1'b1;
        #250 conv_o = 1'b0;
        #60;
        for (int n = 0; n < 34; n++) begin
            sck_o = 1'b1;
            #3 sck_o = 1'b0;
            #1 oe[n] = miso_oe_i;
            bits[n] = miso_i;
            #2;
        end
        #200; // keeps the convert rate below the converter's limit
    endtask
endmodule
